// >>> core/fcmp_pkg.sv
package fcmp_pkg;

  // Register byte offsets
  localparam logic [7:0] FCMP_CTRL_OFF = 8'h00;
  localparam logic [7:0] FCMP_CMD_OFF = 8'h04;
  localparam logic [7:0] FCMP_SRC_OFF = 8'h08;
  localparam logic [7:0] FCMP_STK_DATA_OFF = 8'h0c;
  localparam logic [7:0] FCMP_STK_SEL_OFF = 8'h10;
  localparam logic [7:0] FCMP_SW_OFF = 8'h14;
  localparam logic [7:0] FCMP_FLAGS_OFF = 8'h18;
  localparam logic [7:0] FCMP_EVT_OFF = 8'h1c;
  localparam logic [7:0] FCMP_MASK_OFF = 8'h20;
  localparam logic [7:0] FCMP_TAG_OFF = 8'h24;

  // Numeric status word bit positions
  localparam int SW_IE = 0;
  localparam int SW_DE = 1;
  localparam int SW_SF = 6;
  localparam int SW_C0 = 8;
  localparam int SW_C1 = 9;
  localparam int SW_C2 = 10;
  localparam int SW_TOP_LSB = 11;
  localparam int SW_C3 = 14;

  // Integer flags register bit positions
  localparam int FL_CF = 0;
  localparam int FL_PF = 2;
  localparam int FL_ZF = 6;

  // Event status and mask bit positions
  localparam int EV_DONE = 0;
  localparam int EV_INV = 1;
  localparam int EV_UNDER = 2;
  localparam int EV_DEN = 3;
  localparam int EV_NM = 4;
  localparam int EV_GP = 5;
  localparam int EV_SS = 6;
  localparam int EV_AC = 7;
  localparam int EV_W = 8;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0080;
  localparam logic [15:0] SW_RST = 16'h0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [7:0] TAG_RST = 8'hff;
  localparam logic [EV_W-1:0] MASK_RST = 8'h00;

  // Operation codes
  localparam logic [2:0] OP_STS = 3'h0;
  localparam logic [2:0] OP_STS_P = 3'h1;
  localparam logic [2:0] OP_STS_P2 = 3'h2;
  localparam logic [2:0] OP_USTS = 3'h3;
  localparam logic [2:0] OP_FL = 3'h4;
  localparam logic [2:0] OP_FL_P = 3'h5;
  localparam logic [2:0] OP_UFL = 3'h6;
  localparam logic [2:0] OP_UFL_P = 3'h7;

  // Operating modes and user privilege
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_V86 = 2'h2;
  localparam logic [1:0] CPL_USER = 2'h3;

  // Single-real encoding
  localparam logic [7:0] EXP_MAX = 8'hff;
  localparam int QUIET_BIT = 22;

  typedef enum logic [1:0] {
    FCMP_IDLE = 2'b01,
    FCMP_EXEC = 2'b10
  } fcmp_state_e;

  typedef struct packed {
    logic [12:0] rsvd;
    logic seg_stack;
    logic seg_limit;
    logic seg_null;
    logic unaligned;
    logic ac_en;
    logic [1:0] cpl;
    logic [1:0] mode;
    logic ts;
    logic em;
    logic im;
    logic [2:0] idx;
    logic mem;
    logic [2:0] op;
  } fcmp_ctrl_s;

  typedef struct packed {
    logic sign;
    logic zero;
    logic denorm;
    logic inf;
    logic quiet_not_a_number;
    logic signaling_not_a_number;
  } fcmp_class_s;

  typedef struct packed {
    logic gt;
    logic lt;
    logic eq;
  } fcmp_rel_s;

  // Physical stack slot of ST(off)
  function automatic logic [2:0] fcmp_phys(input logic [2:0] top, input logic [2:0] off);
    return 3'(top + off);
  endfunction

endpackage

// >>> core/fcmp_classify.sv
`timescale 1ns/10ps
module fcmp_classify import fcmp_pkg::*; (
  input wire logic [31:0] val, // Single-real operand
  output fcmp_class_s cls // Operand class
);
  logic [7:0] expo;
  logic [22:0] frac;

  // Field split
  assign expo = val[30:23];
  assign frac = val[22:0];

  // Class decode; a NaN is quiet when its top fraction bit is set
  always_comb begin
    cls.sign = val[31];
    cls.zero = (expo == 8'h00) && (frac == 23'h000000);
    cls.denorm = (expo == 8'h00) && (frac != 23'h000000);
    cls.inf = (expo == EXP_MAX) && (frac == 23'h000000);
    cls.quiet_not_a_number = (expo == EXP_MAX) && frac[QUIET_BIT];
    cls.signaling_not_a_number = (expo == EXP_MAX) && !frac[QUIET_BIT] && (frac != 23'h000000);
  end

endmodule // fcmp_classify

// >>> core/fcmp_compare.sv
`timescale 1ns/10ps
module fcmp_compare import fcmp_pkg::*; (
  input wire logic [31:0] a, // Top operand
  input wire logic [31:0] b, // Source operand
  input fcmp_class_s ca, // Class of a
  input fcmp_class_s cb, // Class of b
  output fcmp_rel_s rel // Ordered relation
);
  logic mag_gt;
  logic mag_eq;

  // Magnitudes order like unsigned integers
  assign mag_gt = a[30:0] > b[30:0];
  assign mag_eq = a[30:0] == b[30:0];

  // Sign-magnitude ordering; NaNs are resolved by the caller
  always_comb begin
    if (ca.zero && cb.zero) begin
      rel = '{gt: 1'b0, lt: 1'b0, eq: 1'b1};
    end else if (a[31] != b[31]) begin
      rel = '{gt: !a[31], lt: a[31], eq: 1'b0};
    end else if (mag_eq) begin
      rel = '{gt: 1'b0, lt: 1'b0, eq: 1'b1};
    end else begin
      rel = '{gt: mag_gt ^ a[31], lt: !(mag_gt ^ a[31]), eq: 1'b0};
    end
  end

endmodule // fcmp_compare

// >>> core/fcmp_unit.sv
// Summary of operation
// - Status compare codes: greater 000, less 001, equal 100
// - Status compare: any NaN invalid; masked writes 111
// - Unordered status compare: quiet NaN raises nothing
// - Pop once, twice, or not per variant
// - Second condition bit always cleared by compares
// - Empty operand underflows; denormal operand flagged
// - Flags compare codes: greater 000, less 001, equal 100
// - Negative and positive zero compare equal
// - Flags compare: any NaN invalid; masked writes 111
// - Unordered flags: quiet NaN gives 111 silently
// - Unmasked invalid leaves result flags unchanged
// - Popping flags compare empties top, bumps pointer
// - Flags compares keep other condition bits
// - Emulation or task-switched bit faults every compare
// - Alignment fault only when enabled at privilege 3 or in V86 mode
// - Null data segment gives protection fault, code 0
// - Segment limit overrun: protection or stack fault
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module fcmp_unit import fcmp_pkg::*; (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error, unmapped
  output logic irq // Level interrupt
);
  fcmp_state_e state_r;
  fcmp_ctrl_s ctrl_r;
  logic [31:0] src_r;
  logic [31:0] stk_r [8];
  logic [2:0] stk_sel_r;
  logic [15:0] sw_r;
  logic [31:0] flags_r;
  logic [7:0] tag_r;
  logic [EV_W-1:0] evt_r;
  logic [EV_W-1:0] evt_nxt;
  logic [EV_W-1:0] mask_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_mux;
  logic go;
  logic ok;
  logic flags_op;
  logic unord;
  logic use_mem;
  logic [2:0] top;
  logic [2:0] src_idx;
  logic [2:0] pa;
  logic [2:0] pb;
  logic [31:0] opa;
  logic [31:0] opb;
  fcmp_class_s ca;
  fcmp_class_s cb;
  fcmp_rel_s rel;
  logic empty;
  logic anynan;
  logic signaling_not_a_number;
  logic den;
  logic inv;
  logic quiet;
  logic write_res;
  logic [2:0] res3;
  logic [1:0] pops;
  logic f_nm;
  logic f_null;
  logic f_lim;
  logic f_ac;
  logic fault;

  // APB phase decode; one wait-free access per transfer
  assign setup = psel && !penable && !pready_r;
  assign wr = psel && penable && pready_r && pwrite;

  // Register read mux
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      FCMP_CTRL_OFF: rd_mux = ctrl_r;
      FCMP_CMD_OFF: rd_mux = {31'h0, state_r == FCMP_EXEC};
      FCMP_SRC_OFF: rd_mux = src_r;
      FCMP_STK_DATA_OFF: rd_mux = stk_r[stk_sel_r];
      FCMP_STK_SEL_OFF: rd_mux = {29'h0, stk_sel_r};
      FCMP_SW_OFF: rd_mux = {16'h0, sw_r};
      FCMP_FLAGS_OFF: rd_mux = flags_r;
      FCMP_EVT_OFF: rd_mux = {24'h0, evt_r};
      FCMP_MASK_OFF: rd_mux = {24'h0, mask_r};
      FCMP_TAG_OFF: rd_mux = {24'h0, tag_r};
      default: hit = 1'b0;
    endcase
  end

  // Answer registered in the setup cycle, so pready is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_r <= setup && !hit;
    end
  end

  // Software-only registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      src_r <= 32'h0000_0000;
      stk_sel_r <= 3'h0;
      mask_r <= MASK_RST;
    end else if (wr) begin
      if (paddr == FCMP_CTRL_OFF) ctrl_r <= pwdata;
      if (paddr == FCMP_SRC_OFF) src_r <= pwdata;
      if (paddr == FCMP_STK_SEL_OFF) stk_sel_r <= pwdata[2:0];
      if (paddr == FCMP_MASK_OFF) mask_r <= pwdata[EV_W-1:0];
    end
  end

  // Stack data array; contents need no reset, tags guard them
  always_ff @(posedge pclk) begin
    if (wr && paddr == FCMP_STK_DATA_OFF) begin
      stk_r[stk_sel_r] <= pwdata;
    end
  end

  // Sequencer: a command write runs one compare cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FCMP_IDLE;
    end else begin
      unique case (state_r)
        FCMP_IDLE: if (wr && paddr == FCMP_CMD_OFF && pwdata[0]) state_r <= FCMP_EXEC;
        FCMP_EXEC: state_r <= FCMP_IDLE;
        default: state_r <= FCMP_IDLE;
      endcase
    end
  end

  // Operand selection
  assign go = state_r == FCMP_EXEC;
  assign flags_op = ctrl_r.op[2];
  assign top = sw_r[SW_TOP_LSB +: 3];
  assign src_idx = (ctrl_r.op == OP_STS_P2) ? 3'h1 : ctrl_r.idx;
  assign use_mem = ctrl_r.mem && !flags_op && ctrl_r.op != OP_STS_P2;
  assign pa = fcmp_phys(top, 3'h0);
  assign pb = fcmp_phys(top, src_idx);
  assign opa = stk_r[pa];
  assign opb = use_mem ? src_r : stk_r[pb];

  fcmp_classify u_cls_a (
    .val(opa),
    .cls(ca)
  );

  fcmp_classify u_cls_b (
    .val(opb),
    .cls(cb)
  );

  fcmp_compare u_cmp (
    .a(opa),
    .b(opb),
    .ca(ca),
    .cb(cb),
    .rel(rel)
  );

  // Fault checks, taken before any arithmetic effect
  // emulation or task switch
  assign f_nm = ctrl_r.em || ctrl_r.ts;
  assign f_null = use_mem && ctrl_r.mode == MODE_PROT && ctrl_r.seg_null;
  assign f_lim = use_mem && ctrl_r.seg_limit;
  assign f_ac = use_mem && ctrl_r.mode != MODE_REAL && ctrl_r.ac_en && ctrl_r.unaligned &&
                (ctrl_r.mode == MODE_V86 || ctrl_r.cpl == CPL_USER);
  assign fault = f_nm || f_null || f_lim || f_ac;
  assign ok = go && !fault;

  // Exception classification; underflow counts as an invalid operand
  assign unord = ctrl_r.op == OP_USTS || ctrl_r.op == OP_UFL || ctrl_r.op == OP_UFL_P;
  assign empty = tag_r[pa] || (!use_mem && tag_r[pb]);
  assign den = !empty && (ca.denorm || cb.denorm);
  assign anynan = !empty && (ca.quiet_not_a_number || ca.signaling_not_a_number || cb.quiet_not_a_number || cb.signaling_not_a_number);
  assign signaling_not_a_number = !empty && (ca.signaling_not_a_number || cb.signaling_not_a_number);
  assign inv = empty || signaling_not_a_number || (anynan && !unord);
  assign quiet = anynan && !inv;
  assign write_res = !inv || ctrl_r.im;
  assign res3 = (quiet || inv) ? 3'b111 : {rel.eq, 1'b0, rel.lt};

  always_comb begin
    pops = 2'h0;
    if (write_res) begin
      unique case (ctrl_r.op)
        OP_STS_P, OP_FL_P, OP_UFL_P: pops = 2'h1;
        OP_STS_P2: pops = 2'h2;
        default: pops = 2'h0;
      endcase
    end
  end

  // Numeric status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_r <= SW_RST;
    end else if (ok) begin
      sw_r[SW_C1] <= 1'b0;
      sw_r[SW_IE] <= sw_r[SW_IE] || inv;
      sw_r[SW_DE] <= sw_r[SW_DE] || den;
      sw_r[SW_SF] <= sw_r[SW_SF] || empty;
      sw_r[SW_TOP_LSB +: 3] <= 3'(top + 3'(pops));
      if (!flags_op && write_res) begin
        sw_r[SW_C3] <= res3[2];
        sw_r[SW_C2] <= res3[1];
        sw_r[SW_C0] <= res3[0];
      end
    end else if (wr && paddr == FCMP_SW_OFF) begin
      sw_r <= pwdata[15:0];
    end
  end

  // Integer flags register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= FLAGS_RST;
    end else if (ok && flags_op && write_res) begin
      flags_r[FL_ZF] <= res3[2];
      flags_r[FL_PF] <= res3[1];
      flags_r[FL_CF] <= res3[0];
    end else if (wr && paddr == FCMP_FLAGS_OFF) begin
      flags_r <= pwdata;
    end
  end

  // Tag bits, 1 means empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_r <= TAG_RST;
    end else if (ok && pops != 2'h0) begin
      tag_r[pa] <= 1'b1;
      if (pops == 2'h2) tag_r[fcmp_phys(top, 3'h1)] <= 1'b1;
    end else if (wr && paddr == FCMP_TAG_OFF) begin
      tag_r <= pwdata[7:0];
    end else if (wr && paddr == FCMP_STK_DATA_OFF) begin
      tag_r[stk_sel_r] <= 1'b0;
    end
  end

  // Sticky events; a set in the clearing cycle wins over the clear
  always_comb begin
    evt_nxt = evt_r;
    if (wr && paddr == FCMP_EVT_OFF) evt_nxt = evt_r & ~pwdata[EV_W-1:0];
    if (go) begin
      evt_nxt[EV_DONE] = 1'b1;
      evt_nxt[EV_NM] = evt_nxt[EV_NM] || f_nm;
      evt_nxt[EV_GP] = evt_nxt[EV_GP] || (!f_nm && (f_null || (f_lim && !ctrl_r.seg_stack)));
      evt_nxt[EV_SS] = evt_nxt[EV_SS] || (!f_nm && !f_null && f_lim && ctrl_r.seg_stack);
      evt_nxt[EV_AC] = evt_nxt[EV_AC] || (!f_nm && !f_null && !f_lim && f_ac);
      evt_nxt[EV_INV] = evt_nxt[EV_INV] || (ok && inv);
      evt_nxt[EV_UNDER] = evt_nxt[EV_UNDER] || (ok && empty);
      evt_nxt[EV_DEN] = evt_nxt[EV_DEN] || (ok && den);
    end
  end

  // Interrupt follows masked status one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= '0;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq_r <= |(evt_r & mask_r);
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable && !pready_r;
  endsequence

  sequence masked_nan_s;
    ok && ctrl_r.op == OP_STS && anynan && ctrl_r.im;
  endsequence

  apb_answer_a: assert property (setup_s |=> pready_r ##1 !pready_r)
    else $error("APB answer not a single cycle");
  cc_order_a: assert property (ok && !flags_op && !inv && !quiet |=>
    {sw_r[SW_C3], sw_r[SW_C2], sw_r[SW_C0]} == $past({rel.eq, 1'b0, rel.lt}))
    else $error("Status condition code wrong");
  cc_unord_a: assert property (masked_nan_s |=>
    {sw_r[SW_C3], sw_r[SW_C2], sw_r[SW_C0]} == 3'b111 && sw_r[SW_IE])
    else $error("Masked NaN not unordered");
  unord_quiet_a: assert property (ok && ctrl_r.op == OP_USTS && quiet |=>
    sw_r[SW_IE] == $past(sw_r[SW_IE]))
    else $error("Quiet NaN raised invalid");
  pop_twice_a: assert property (ok && ctrl_r.op == OP_STS_P2 && write_res |=>
    sw_r[SW_TOP_LSB +: 3] == 3'($past(top) + 3'h2))
    else $error("Double pop wrong");
  cond_second_a: assert property (ok |=> !sw_r[SW_C1])
    else $error("Second condition bit set");
  flags_unord_a: assert property (ok && ctrl_r.op == OP_UFL && quiet |=>
    flags_r[FL_ZF] && flags_r[FL_PF] && flags_r[FL_CF] && $stable(evt_r[EV_INV]))
    else $error("Quiet unordered flags wrong");
  hold_flags_a: assert property (ok && inv && !ctrl_r.im |=>
    $stable(flags_r) && $stable(tag_r))
    else $error("Unmasked invalid changed state");
  cc_keep_a: assert property (ok && flags_op |=>
    $stable(sw_r[SW_C3]) && $stable(sw_r[SW_C2]) && $stable(sw_r[SW_C0]))
    else $error("Flags compare touched condition bits");
  nm_fault_a: assert property (go && f_nm |=> evt_r[EV_NM] && $stable(sw_r) && $stable(flags_r))
    else $error("Unavailable device executed");
  irq_level_a: assert property (irq_r == $past(|(evt_r & mask_r)))
    else $error("Interrupt missing");

endmodule // fcmp_unit

// >>> test/fcmp_seq_model.sv
`timescale 1ns/10ps
// Sequencer side of the unit: issues APB cycles for the bench
module fcmp_seq_model (
  input wire logic pclk, // Core clock
  input wire logic pready, // Slave ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Slave error
  output logic [7:0] paddr, // Address
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [31:0] pwdata // Write data
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; the wait is unbounded here, the bench watchdog cuts a hang
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines do not keep the old word
    pwdata <= ~d;
  endtask
endmodule // fcmp_seq_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench import fcmp_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata, rv;
  logic ev;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rng = 32'hf83f;
  logic [31:0] vals [8] = '{32'h3f800000, 32'h40000000, 32'hbf800000, 32'h00000000,
                            32'h80000000, 32'h00000001, 32'h7fc00000, 32'h7f800001};
  logic [31:0] fext [9] = '{32'h100, 32'h200, 32'h10400, 32'h10000, 32'h20000, 32'h60000,
                            32'hf400, 32'hc400, 32'hc800};
  logic [7:0] fevt [9] = '{8'h10, 8'h10, 8'h20, 8'h00, 8'h20, 8'h40, 8'h80, 8'h00, 8'h80};

  // 50 MHz core clock
  always #10 pclk = ~pclk;

  fcmp_unit uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
  fcmp_seq_model seq (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic isnan(input logic [31:0] v);
    return v[30:23] == 8'hff && v[22:0] != 23'h0;
  endfunction

  // Relation code high/middle/low; both zeros equal whatever the sign
  function automatic logic [2:0] rel(input logic [31:0] a, input logic [31:0] b);
    int ka, kb;
    if (isnan(a) || isnan(b)) return 3'b111;
    if (a[30:0] == 31'h0 && b[30:0] == 31'h0) return 3'b100;
    ka = a[31] ? -int'(a[30:0]) : int'(a[30:0]);
    kb = b[31] ? -int'(b[30:0]) : int'(b[30:0]);
    return (ka > kb) ? 3'b000 : (ka < kb) ? 3'b001 : 3'b100;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    seq.xfer(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    seq.xfer(a, 1'b0, 32'h0, d, e);
  endtask

  // One compare from a full stack with TOP at zero, random prior codes
  task automatic cmp(input logic [2:0] op, input logic [2:0] idx, input logic im,
                     input logic [31:0] a, input logic [31:0] b);
    logic [31:0] r;
    logic [2:0] p, f, c, cs, fl;
    logic inv, den, hold;
    logic [1:0] pops;
    p = 3'(rnd());
    f = 3'(rnd());
    wr(FCMP_TAG_OFF, 32'h0);
    wr(FCMP_SW_OFF, {17'h0, p[2], 3'b000, p[1], 1'b1, p[0], 8'h00});
    wr(FCMP_FLAGS_OFF, {25'h0, f[2], 3'b000, f[1], 1'b0, f[0]});
    wr(FCMP_EVT_OFF, 32'hff);
    wr(FCMP_STK_SEL_OFF, 32'h0);
    wr(FCMP_STK_DATA_OFF, a);
    wr(FCMP_STK_SEL_OFF, (op == OP_STS_P2) ? 32'h1 : {29'h0, idx});
    wr(FCMP_STK_DATA_OFF, b);
    wr(FCMP_CTRL_OFF, {24'h0, im, idx, 1'b0, op});
    wr(FCMP_CMD_OFF, 32'h1);
    // Unordered kinds only object to signaling operands
    inv = (op == OP_USTS || op == OP_UFL || op == OP_UFL_P) ?
          ((isnan(a) && !a[QUIET_BIT]) || (isnan(b) && !b[QUIET_BIT])) : (isnan(a) || isnan(b));
    den = (a[30:23] == 8'h0 && a[22:0] != 23'h0) || (b[30:23] == 8'h0 && b[22:0] != 23'h0);
    hold = inv && !im;
    c = rel(a, b);
    cs = (op < OP_FL && !hold) ? c : p;
    fl = (op >= OP_FL && !hold) ? c : f;
    pops = hold ? 2'd0 : (op == OP_STS_P || op == OP_FL_P || op == OP_UFL_P) ? 2'd1 :
           (op == OP_STS_P2) ? 2'd2 : 2'd0;
    rd(FCMP_SW_OFF, r);
    chk("status", {17'h0, cs[2], 1'b0, pops, cs[1], 1'b0, cs[0], 6'h0, den, inv}, r);
    rd(FCMP_FLAGS_OFF, r);
    chk("flags", {25'h0, fl[2], 3'b000, fl[1], 1'b0, fl[0]}, r);
    rd(FCMP_TAG_OFF, r);
    chk("tags", (pops == 2'd2) ? 32'h3 : {31'h0, pops[0]}, r);
    rd(FCMP_EVT_OFF, r);
    chk("events", {28'h0, den, 1'b0, inv, 1'b1}, r);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the expected run of a few thousand cycles
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rd(FCMP_CTRL_OFF, rv);
    chk("ctrl reset", CTRL_RST, rv);
    rd(FCMP_TAG_OFF, rv);
    chk("tag reset", {24'h0, TAG_RST}, rv);
    rd(FCMP_MASK_OFF, rv);
    chk("mask reset", 32'h0, rv);
    seq.xfer(8'h40, 1'b0, 32'h0, rv, ev);
    chk("unmapped err", 32'h1, {31'h0, ev});
    chk("unmapped data", 32'h0, rv);
    // Quiet operand through every kind, masked and unmasked
    for (int k = 0; k < 16; k++) cmp(3'(k), 3'd3, k[3], 32'h7fc00000, 32'h3f800000);
    cmp(OP_FL, 3'd1, 1'b1, 32'h80000000, 32'h0);
    // Empty source slot: masked underflow gives unordered codes and still pops
    wr(FCMP_EVT_OFF, 32'hff);
    wr(FCMP_SW_OFF, 32'h0);
    wr(FCMP_TAG_OFF, 32'h2);
    wr(FCMP_CTRL_OFF, {24'h0, 1'b1, 3'd1, 1'b0, OP_STS_P});
    wr(FCMP_CMD_OFF, 32'h1);
    rd(FCMP_SW_OFF, rv);
    chk("underflow status", 32'h4d41, rv);
    rd(FCMP_EVT_OFF, rv);
    chk("underflow events", 32'h7, rv);
    rd(FCMP_TAG_OFF, rv);
    chk("underflow tags", 32'h3, rv);
    repeat (40) cmp(3'(rnd()), 3'(rnd() % 7 + 1), 1'(rnd()), vals[rnd() % 8], vals[rnd() % 8]);
    // Faults by mode; a fault keeps the status word
    for (int k = 0; k < 9; k++) begin
      wr(FCMP_EVT_OFF, 32'hff);
      wr(FCMP_SRC_OFF, 32'h3f800000);
      wr(FCMP_STK_SEL_OFF, 32'h0);
      wr(FCMP_STK_DATA_OFF, 32'h40000000);
      wr(FCMP_TAG_OFF, 32'h0);
      wr(FCMP_SW_OFF, 32'h4500);
      wr(FCMP_CTRL_OFF, fext[k] | 32'h88);
      wr(FCMP_CMD_OFF, 32'h1);
      rd(FCMP_EVT_OFF, rv);
      chk("fault event", {24'h0, fevt[k] | 8'h01}, rv);
      rd(FCMP_SW_OFF, rv);
      chk("fault status", (fevt[k] != 8'h0) ? 32'h4500 : 32'h0, rv);
    end
    // Interrupt raised, cleared, then masked
    wr(FCMP_MASK_OFF, 32'h1);
    wr(FCMP_EVT_OFF, 32'hff);
    wr(FCMP_CMD_OFF, 32'h1);
    rd(FCMP_MASK_OFF, rv);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(FCMP_EVT_OFF, 32'h1);
    rd(FCMP_EVT_OFF, rv);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(FCMP_MASK_OFF, 32'h0);
    wr(FCMP_CMD_OFF, 32'h1);
    rd(FCMP_EVT_OFF, rv);
    chk("irq masked", 32'h0, {31'h0, irq});
    give_verdict();
  end
endmodule // testbench
